/* File: design/ebpc_pkg.sv */
// Purpose: shared constants and types of the external bus and port control block
// Assumes: 32-bit classic wishbone, register index times four is the byte address
// Notes: function-select reset values depend on the operating mode
package ebpc_pkg;
  localparam int unsigned IDX_W = 4;
  localparam logic [IDX_W-1:0] IDX_PORT_A_DATA = 4'h0;
  localparam logic [IDX_W-1:0] IDX_PORT_B_DATA = 4'h1;
  localparam logic [IDX_W-1:0] IDX_PORT_A_DIRECTION = 4'h2;
  localparam logic [IDX_W-1:0] IDX_PORT_B_DIRECTION = 4'h3;
  localparam logic [IDX_W-1:0] IDX_PORT_E_DATA = 4'h8;
  localparam logic [IDX_W-1:0] IDX_PORT_E_DIRECTION = 4'h9;
  localparam logic [IDX_W-1:0] IDX_PORT_E_FUNCTION_SELECT = 4'ha;
  localparam logic [IDX_W-1:0] IDX_PULLUP_CONTROL = 4'he;
  localparam logic [IDX_W-1:0] IDX_MODE_STATUS = 4'hf;
  localparam int unsigned IDX_LSB = 2;
  localparam logic [7:0] PORT_RESET = 8'h00;
  // pins 7,3,2,1,0 carry the shared pull-up
  localparam logic [7:0] PULLUP_PIN_MASK = 8'h8f;
  // interrupt inputs can never drive
  localparam logic [7:0] PE_INPUT_ONLY_MASK = 8'h03;

  typedef enum logic [2:0] {
    EBPC_NORMAL_SINGLE,
    EBPC_SPECIAL_SINGLE,
    EBPC_NORMAL_NARROW,
    EBPC_NORMAL_WIDE,
    EBPC_SPECIAL_NARROW,
    EBPC_SPECIAL_WIDE,
    EBPC_PERIPHERAL
  } ebpc_mode_t;

  typedef struct packed {
    logic no_data_enable_bit;
    logic clockgen_test_enable;
    logic pipe_output_enable;
    logic no_bus_e_clock_output;
    logic low_strobe_enable;
    logic rw_pin_enable;
    logic calibration_ref_enable;
    logic pe7_enable_select;
  } ebpc_port_e_function_select_t;

  typedef struct packed {
    logic byte_strobe_n;
    logic address_bit_zero;
    logic rw;
  } ebpc_busctl_t;

  localparam logic [7:0] PORT_E_FUNCTION_SELECT_RST_NORMAL_EXP = 8'h00;
  localparam logic [7:0] PORT_E_FUNCTION_SELECT_RST_SPECIAL = 8'h2c;
  localparam logic [7:0] PORT_E_FUNCTION_SELECT_RST_PERIPHERAL = 8'hd0;
  localparam logic [7:0] PORT_E_FUNCTION_SELECT_RST_NORMAL_SINGLE = 8'h90;
endpackage

/* File: design/ebpc_top.sv */
// Purpose: external bus control encoding, port A/B/E pin steering and their registers
// Assumes: mode and emulate flag are straps, taken at the first edge after reset release
// Notes: registers removed from the map answer zero and, below index 0xe, pulse EXT_ACCESS_O instead
// Operation
// RULE1: byte access: strobe/a0 per even or odd
// RULE2: aligned word: strobe and a0 both low
// RULE3: strobe and a0 high only ram swap
// RULE4: swap puts addressed byte on low half
// RULE5: peripheral mode removes first sixteen registers
// RULE6: expanded/peripheral: port A, B registers external
// RULE7: emulate flag or peripheral: port E external; code ignores the flag in single chip modes, port E stays on chip
// RULE8: port A carries high address/data, narrow low data
// RULE9: port B carries low address, data unless narrow
// RULE10: direction 0 input, 1 output
// RULE11: single chip: ports A, B general I/O
// RULE12: port E bits 1..0 input only, readable
// RULE13: one bit enables pull-ups on input pins
// RULE14: alternate function overrides port E direction
// RULE15: normal single chip: port E all I/O
// RULE16: normal expanded: only data enable, E clock
// RULE17: special expanded: six bus-control functions on
// RULE18: peripheral: select register ignored, test bit one
// RULE19: no-data-enable bit picks bit 7 function
// RULE20: no-data-enable write once or skip first
// RULE21: test bit drives bit 6, pipe overrides
// RULE22: test bit never in normal, skip first
// RULE23: first-write flag per register, cleared by reset
//
// Our own choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module ebpc_top (
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [7:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [31:0] DAT_I,
  output logic [31:0] DAT_O,
  output logic ACK_O,
  output logic EXT_ACCESS_O,
  input wire logic [2:0] MODE_I,
  input wire logic EMULATE_PORT_E_FLAG_I,
  input wire logic CPU_REQ_I,
  input wire logic [15:0] CPU_ADDR_I,
  input wire logic CPU_WE_I,
  input wire logic CPU_WIDE_I,
  input wire logic CPU_RAM_I,
  input wire logic [15:0] CPU_WDATA_I,
  input wire logic ADDR_PHASE_I,
  input wire logic BUS_E_CLOCK_I,
  input wire logic DATA_BUS_ENABLE_I,
  input wire logic QUEUE_STATUS_HI_I,
  input wire logic QUEUE_STATUS_LO_I,
  input wire logic CLOCKGEN_TEST_I,
  input wire logic CALIBRATION_I,
  input wire logic [7:0] PA_I,
  output logic [7:0] PA_O,
  output logic [7:0] PA_OE_O,
  input wire logic [7:0] PB_I,
  output logic [7:0] PB_O,
  output logic [7:0] PB_OE_O,
  input wire logic [7:0] PE_I,
  output logic [7:0] PE_O,
  output logic [7:0] PE_OE_O,
  output logic [7:0] PULLUP_O
);
  logic loaded;
  ebpc_pkg::ebpc_mode_t mode;
  logic emulate;
  logic [7:0] port_a_data, port_b_data, port_a_direction, port_b_direction;
  logic [7:0] port_e_data, port_e_direction;
  ebpc_pkg::ebpc_port_e_function_select_t port_e_function_select;
  logic port_e_function_select_written;
  logic pullup_enable;
  logic single, expanded, special, narrow, periph, normal_narrow;
  logic ab_on_chip, e_on_chip;
  logic [ebpc_pkg::IDX_W-1:0] idx;
  logic hit_range, mapped, req, wr_now;
  logic [7:0] rd_byte;
  logic [15:0] lanes;
  ebpc_pkg::ebpc_busctl_t next_busctl;
  ebpc_pkg::ebpc_busctl_t busctl;
  logic [7:0] next_pe_o, next_pe_oe;
  logic [7:0] next_pa_o, next_pa_oe, next_pb_o, next_pb_oe;
  ebpc_pkg::ebpc_port_e_function_select_t port_e_function_select_reset;

  always_comb begin
    single = (mode == ebpc_pkg::EBPC_NORMAL_SINGLE) || (mode == ebpc_pkg::EBPC_SPECIAL_SINGLE);
    periph = (mode == ebpc_pkg::EBPC_PERIPHERAL);
    expanded = !single && !periph;
    special = (mode == ebpc_pkg::EBPC_SPECIAL_SINGLE) || (mode == ebpc_pkg::EBPC_SPECIAL_NARROW)
      || (mode == ebpc_pkg::EBPC_SPECIAL_WIDE);
    narrow = (mode == ebpc_pkg::EBPC_NORMAL_NARROW) || (mode == ebpc_pkg::EBPC_SPECIAL_NARROW);
    normal_narrow = (mode == ebpc_pkg::EBPC_NORMAL_NARROW);
    ab_on_chip = single; // [RULE6] [RULE11]
    e_on_chip = single || (expanded && !emulate); // [RULE7]
  end

  // mode straps are sampled after release so the reset itself stays constant
  always_comb begin
    case (ebpc_pkg::ebpc_mode_t'(MODE_I))
      ebpc_pkg::EBPC_NORMAL_SINGLE: port_e_function_select_reset = ebpc_pkg::PORT_E_FUNCTION_SELECT_RST_NORMAL_SINGLE; // [RULE15]
      ebpc_pkg::EBPC_NORMAL_NARROW, ebpc_pkg::EBPC_NORMAL_WIDE:
        port_e_function_select_reset = ebpc_pkg::PORT_E_FUNCTION_SELECT_RST_NORMAL_EXP; // [RULE16]
      ebpc_pkg::EBPC_PERIPHERAL: port_e_function_select_reset = ebpc_pkg::PORT_E_FUNCTION_SELECT_RST_PERIPHERAL; // [RULE18]
      default: port_e_function_select_reset = ebpc_pkg::PORT_E_FUNCTION_SELECT_RST_SPECIAL; // [RULE17]
    endcase
  end

  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      loaded <= 1'b0;
      mode <= ebpc_pkg::EBPC_NORMAL_SINGLE;
      emulate <= 1'b0;
    end else if (!loaded) begin
      loaded <= 1'b1;
      mode <= ebpc_pkg::ebpc_mode_t'(MODE_I);
      emulate <= EMULATE_PORT_E_FLAG_I;
    end
  end

  // wishbone slave: one wait state, ack for one cycle, write at the ack edge
  always_comb begin
    idx = ADR_I[ebpc_pkg::IDX_LSB +: ebpc_pkg::IDX_W];
    hit_range = (ADR_I[7:6] == 2'b00) && (ADR_I[1:0] == 2'b00);
    req = CYC_I && STB_I && loaded;
    case (idx)
      ebpc_pkg::IDX_PORT_A_DATA, ebpc_pkg::IDX_PORT_B_DATA,
      ebpc_pkg::IDX_PORT_A_DIRECTION, ebpc_pkg::IDX_PORT_B_DIRECTION: mapped = ab_on_chip;
      ebpc_pkg::IDX_PORT_E_DATA, ebpc_pkg::IDX_PORT_E_DIRECTION: mapped = e_on_chip;
      ebpc_pkg::IDX_PORT_E_FUNCTION_SELECT, ebpc_pkg::IDX_PULLUP_CONTROL,
      ebpc_pkg::IDX_MODE_STATUS: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
    mapped = mapped && hit_range && !periph; // [RULE5] [RULE18]
    wr_now = req && ACK_O && WE_I && SEL_I[0] && mapped;
    case (idx)
      ebpc_pkg::IDX_PORT_A_DATA: rd_byte = (port_a_data & port_a_direction) | (PA_I & ~port_a_direction);
      ebpc_pkg::IDX_PORT_B_DATA: rd_byte = (port_b_data & port_b_direction) | (PB_I & ~port_b_direction);
      ebpc_pkg::IDX_PORT_A_DIRECTION: rd_byte = port_a_direction;
      ebpc_pkg::IDX_PORT_B_DIRECTION: rd_byte = port_b_direction;
      ebpc_pkg::IDX_PORT_E_DATA: rd_byte = (port_e_data & port_e_direction) | (PE_I & ~port_e_direction); // [RULE12]
      ebpc_pkg::IDX_PORT_E_DIRECTION: rd_byte = port_e_direction;
      ebpc_pkg::IDX_PORT_E_FUNCTION_SELECT: rd_byte = port_e_function_select;
      ebpc_pkg::IDX_PULLUP_CONTROL: rd_byte = {7'h00, pullup_enable};
      ebpc_pkg::IDX_MODE_STATUS: rd_byte = {3'h0, emulate, port_e_function_select_written, mode};
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      ACK_O <= 1'b0;
      DAT_O <= 32'h0000_0000;
      EXT_ACCESS_O <= 1'b0;
    end else begin
      ACK_O <= req && !ACK_O;
      DAT_O <= (req && !ACK_O && !WE_I && mapped) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      // any off-map index below the pull-up control index is handed to the external bus, unmapped ones too
      EXT_ACCESS_O <= req && !ACK_O && hit_range && !mapped && (idx < ebpc_pkg::IDX_PULLUP_CONTROL); // [RULE6]
    end
  end

  // plain port registers, writable any time while on chip
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      port_a_data <= ebpc_pkg::PORT_RESET;
      port_b_data <= ebpc_pkg::PORT_RESET;
      port_a_direction <= ebpc_pkg::PORT_RESET;
      port_b_direction <= ebpc_pkg::PORT_RESET;
      port_e_data <= ebpc_pkg::PORT_RESET;
      port_e_direction <= ebpc_pkg::PORT_RESET;
      pullup_enable <= 1'b0;
    end else if (wr_now) begin
      case (idx)
        ebpc_pkg::IDX_PORT_A_DATA: port_a_data <= DAT_I[7:0]; // [RULE11]
        ebpc_pkg::IDX_PORT_B_DATA: port_b_data <= DAT_I[7:0];
        ebpc_pkg::IDX_PORT_A_DIRECTION: port_a_direction <= DAT_I[7:0];
        ebpc_pkg::IDX_PORT_B_DIRECTION: port_b_direction <= DAT_I[7:0];
        ebpc_pkg::IDX_PORT_E_DATA: port_e_data <= DAT_I[7:0];
        ebpc_pkg::IDX_PORT_E_DIRECTION: port_e_direction <= DAT_I[7:0] & ~ebpc_pkg::PE_INPUT_ONLY_MASK; // [RULE12]
        ebpc_pkg::IDX_PULLUP_CONTROL: pullup_enable <= DAT_I[0];
        default: ;
      endcase
    end
  end

  // function select: bit 1 takes every write, bits 7,5,3,2,0 once in normal modes, skip the first in special; bit 6 special only, bit 4 single chip only
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      port_e_function_select <= '0;
      port_e_function_select_written <= 1'b0; // [RULE23]
    end else if (!loaded) begin
      port_e_function_select <= port_e_function_select_reset;
    end else if (wr_now && idx == ebpc_pkg::IDX_PORT_E_FUNCTION_SELECT) begin
      port_e_function_select_written <= 1'b1; // [RULE23]
      port_e_function_select.calibration_ref_enable <= DAT_I[1];
      if (special ? port_e_function_select_written : !port_e_function_select_written) begin
        port_e_function_select.no_data_enable_bit <= DAT_I[7]; // [RULE20]
        port_e_function_select.pipe_output_enable <= DAT_I[5];
        port_e_function_select.low_strobe_enable <= DAT_I[3];
        port_e_function_select.rw_pin_enable <= DAT_I[2];
        port_e_function_select.pe7_enable_select <= DAT_I[0];
      end
      if (special && port_e_function_select_written) begin
        port_e_function_select.clockgen_test_enable <= DAT_I[6]; // [RULE22]
      end
      if ((mode == ebpc_pkg::EBPC_NORMAL_SINGLE && !port_e_function_select_written) || mode == ebpc_pkg::EBPC_SPECIAL_SINGLE) begin
        port_e_function_select.no_bus_e_clock_output <= DAT_I[4];
      end
    end
  end

  // external access encoding
  always_comb begin
    next_busctl.address_bit_zero = CPU_ADDR_I[0];
    next_busctl.rw = !CPU_WE_I; // [RULE1]
    if (CPU_WIDE_I && !CPU_ADDR_I[0]) begin
      next_busctl.byte_strobe_n = 1'b0; // [RULE2]
    end else if (CPU_WIDE_I && CPU_RAM_I) begin
      next_busctl.byte_strobe_n = 1'b1; // [RULE3]
    end else begin
      next_busctl.byte_strobe_n = !CPU_ADDR_I[0]; // [RULE1]
    end
    // big-endian word: the addressed byte normally rides the high half
    if (next_busctl.byte_strobe_n && next_busctl.address_bit_zero) begin
      lanes = {CPU_WDATA_I[7:0], CPU_WDATA_I[15:8]}; // [RULE4]
    end else begin
      lanes = CPU_WDATA_I;
    end
  end

  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      busctl <= '{byte_strobe_n: 1'b1, address_bit_zero: 1'b0, rw: 1'b1};
    end else if (CPU_REQ_I && expanded) begin
      busctl <= next_busctl;
    end
  end

  // pin steering
  always_comb begin
    if (expanded || periph) begin
      next_pa_o = ADDR_PHASE_I ? CPU_ADDR_I[15:8] : ((narrow && CPU_ADDR_I[0]) ? lanes[7:0] : lanes[15:8]); // [RULE8]
      next_pa_oe = {8{ADDR_PHASE_I || CPU_WE_I}};
      next_pb_o = (ADDR_PHASE_I || narrow) ? CPU_ADDR_I[7:0] : lanes[7:0]; // [RULE9]
      next_pb_oe = {8{ADDR_PHASE_I || narrow || CPU_WE_I}};
    end else begin
      next_pa_o = port_a_data;
      next_pa_oe = port_a_direction; // [RULE10]
      next_pb_o = port_b_data;
      next_pb_oe = port_b_direction;
    end
    next_pe_o = port_e_data;
    next_pe_oe = port_e_direction & ~ebpc_pkg::PE_INPUT_ONLY_MASK; // [RULE10] [RULE12]
    if (expanded && !port_e_function_select.no_data_enable_bit) begin
      next_pe_o[7] = port_e_function_select.pe7_enable_select ? !BUS_E_CLOCK_I : DATA_BUS_ENABLE_I; // [RULE19] [RULE14]
      next_pe_oe[7] = 1'b1;
    end else if (port_e_function_select.calibration_ref_enable) begin
      next_pe_o[7] = CALIBRATION_I; // [RULE19]
      next_pe_oe[7] = 1'b1;
    end
    if (expanded && port_e_function_select.pipe_output_enable) begin
      next_pe_o[6:5] = {QUEUE_STATUS_HI_I, QUEUE_STATUS_LO_I}; // [RULE21]
      next_pe_oe[6:5] = 2'b11;
    end else if (port_e_function_select.clockgen_test_enable && !single && mode != ebpc_pkg::EBPC_NORMAL_NARROW
        && mode != ebpc_pkg::EBPC_NORMAL_WIDE) begin
      next_pe_o[6] = CLOCKGEN_TEST_I; // [RULE21]
      next_pe_oe[6] = 1'b1;
    end
    if (!port_e_function_select.no_bus_e_clock_output) begin
      next_pe_o[4] = BUS_E_CLOCK_I; // [RULE14]
      next_pe_oe[4] = !periph;
    end
    if (port_e_function_select.low_strobe_enable && !single && !normal_narrow) begin
      next_pe_o[3] = busctl.byte_strobe_n; // [RULE14]
      next_pe_oe[3] = 1'b1;
    end
    if (port_e_function_select.rw_pin_enable && !single) begin
      next_pe_o[2] = busctl.rw; // [RULE14]
      next_pe_oe[2] = 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      PA_O <= 8'h00;
      PA_OE_O <= 8'h00;
      PB_O <= 8'h00;
      PB_OE_O <= 8'h00;
      PE_O <= 8'h00;
      PE_OE_O <= 8'h00;
      PULLUP_O <= 8'h00;
    end else begin
      PA_O <= next_pa_o;
      PA_OE_O <= next_pa_oe;
      PB_O <= next_pb_o;
      PB_OE_O <= next_pb_oe;
      PE_O <= next_pe_o;
      PE_OE_O <= next_pe_oe;
      PULLUP_O <= {8{pullup_enable}} & ebpc_pkg::PULLUP_PIN_MASK & ~next_pe_oe; // [RULE13]
    end
  end

  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (RST_I);

  sequence byte_even_req;
    CPU_REQ_I && expanded && !CPU_WIDE_I && !CPU_ADDR_I[0];
  endsequence
  sequence word_even_req;
    CPU_REQ_I && expanded && CPU_WIDE_I && !CPU_ADDR_I[0];
  endsequence
  sequence select_write_ack;
    req && ACK_O && WE_I && SEL_I[0] && mapped && idx == ebpc_pkg::IDX_PORT_E_FUNCTION_SELECT;
  endsequence

  byte_even_strobe_a: assert property (byte_even_req |=> busctl.byte_strobe_n && !busctl.address_bit_zero // [RULE1]
    && busctl.rw == !$past(CPU_WE_I)) else $error("even byte encoding wrong");
  word_even_strobe_a: assert property (word_even_req |=> !busctl.byte_strobe_n && !busctl.address_bit_zero) // [RULE2]
    else $error("aligned word encoding wrong");
  swap_source_a: assert property ($rose(busctl.byte_strobe_n && busctl.address_bit_zero) // [RULE3]
    |-> $past(CPU_RAM_I && CPU_WIDE_I)) else $error("swap without ram access");
  periph_unmap_a: assert property (periph && req && !ACK_O |=> ACK_O && DAT_O == 32'h0000_0000) // [RULE5]
    else $error("register visible in peripheral mode");
  port_a_ext_a: assert property (!single && req && !ACK_O && hit_range && idx == ebpc_pkg::IDX_PORT_A_DATA // [RULE6]
    |=> EXT_ACCESS_O) else $error("port A register stayed on chip");
  pe_low_input_a: assert property (PE_OE_O[1:0] == 2'b00) else $error("interrupt pin driven"); // [RULE12]
  cgm_normal_a: assert property (loaded && !special && !periph |=> $stable(port_e_function_select.clockgen_test_enable)) // [RULE22]
    else $error("test bit changed in normal mode");
  no_data_enable_bit_first_a: assert property (select_write_ack ##0 (special && !port_e_function_select_written) // [RULE20]
    |=> $stable(port_e_function_select.no_data_enable_bit)) else $error("first special write taken");
  written_flag_a: assert property (select_write_ack |=> port_e_function_select_written [*3]) // [RULE23]
    else $error("first-write flag lost");
  // strobe pin shows the encoding latched one edge earlier, never the port E direction bit
  byte_strobe_n_pin_a: assert property (port_e_function_select.low_strobe_enable && !single && !normal_narrow |=> PE_OE_O[3] // [RULE14]
    && PE_O[3] == $past(busctl.byte_strobe_n)) else $error("strobe pin not steered");
  pa_dir_single_a: assert property (single && loaded |=> PA_OE_O == $past(port_a_direction)) // [RULE10]
    else $error("port A direction not applied");
endmodule
`default_nettype wire

/* File: verification/ebpc_pin_model.sv */
// Purpose: pin-side model of the external memories and port replacement unit for one 8-bit port
// Assumes: the device wins wherever its output enable is high
// Notes: an undriven pin without pull-up shows the inverse of its last level
`timescale 1ns/1ps
`default_nettype none
module ebpc_pin_model (
  input wire logic clk_i,
  input wire logic [7:0] dev_out_i,
  input wire logic [7:0] dev_oe_i,
  input wire logic [7:0] pull_i,
  input wire logic [7:0] ext_val_i,
  input wire logic [7:0] ext_en_i,
  output logic [7:0] level_o
);
  logic [7:0] last = 8'h00;
  always @(posedge clk_i) begin
    last <= level_o;
  end
  // a floating pin must never look stable, or a missing drive would pass unseen
  assign level_o = (dev_oe_i & dev_out_i) | (~dev_oe_i & ext_en_i & ext_val_i) |
                   (~dev_oe_i & ~ext_en_i & (pull_i | ~last));
endmodule
`default_nettype wire

/* File: verification/ebpc_top_tb_top.sv */
// Purpose: self-checking bench for the external bus and port control block
// Assumes: classic wishbone with one wait state, straps taken at reset release
// Notes: each mode is entered by a fresh reset with new strap values
`timescale 1ns/1ps
`default_nettype none
module ebpc_top_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, emulate_port_e_flag = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h00000000;
  logic [2:0] mode = 3'h0;
  logic cpu_req = 1'b0, cpu_we = 1'b0, cpu_wide = 1'b0, cpu_ram = 1'b0, addr_phase = 1'b1;
  logic [15:0] cpu_addr = 16'h0000, cpu_wdata = 16'h0000;
  logic bus_e_clock = 1'b0, dbe = 1'b1, qhi = 1'b0, qlo = 1'b1, cgt = 1'b1, cal = 1'b1;
  logic [7:0] pa_ext = 8'h3c, pb_ext = 8'h00, pe_ext = 8'h02, ext_en = 8'hff;
  logic [7:0] pa_lvl, pb_lvl, pe_lvl, pa_o, pa_oe, pb_o, pb_oe, pe_o, pe_oe, pull, rd;
  logic [31:0] dat_o;
  logic ack, ext, ext_seen;
  int miscompares = 0;
  int samples_checked = 0;

  initial begin
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    bus_e_clock <= ~bus_e_clock;
  end

  ebpc_top i_dut (
    .CLK_SYS_I(clk), .RST_I(rst), .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr), .SEL_I(sel),
    .DAT_I(dat), .DAT_O(dat_o), .ACK_O(ack), .EXT_ACCESS_O(ext), .MODE_I(mode), .EMULATE_PORT_E_FLAG_I(emulate_port_e_flag),
    .CPU_REQ_I(cpu_req), .CPU_ADDR_I(cpu_addr), .CPU_WE_I(cpu_we), .CPU_WIDE_I(cpu_wide), .CPU_RAM_I(cpu_ram),
    .CPU_WDATA_I(cpu_wdata), .ADDR_PHASE_I(addr_phase), .BUS_E_CLOCK_I(bus_e_clock), .DATA_BUS_ENABLE_I(dbe),
    .QUEUE_STATUS_HI_I(qhi), .QUEUE_STATUS_LO_I(qlo), .CLOCKGEN_TEST_I(cgt), .CALIBRATION_I(cal),
    .PA_I(pa_lvl), .PA_O(pa_o), .PA_OE_O(pa_oe), .PB_I(pb_lvl), .PB_O(pb_o), .PB_OE_O(pb_oe),
    .PE_I(pe_lvl), .PE_O(pe_o), .PE_OE_O(pe_oe), .PULLUP_O(pull)
  );
  ebpc_pin_model i_pa (.clk_i(clk), .dev_out_i(pa_o), .dev_oe_i(pa_oe), .pull_i(8'h00),
    .ext_val_i(pa_ext), .ext_en_i(ext_en), .level_o(pa_lvl));
  ebpc_pin_model i_pb (.clk_i(clk), .dev_out_i(pb_o), .dev_oe_i(pb_oe), .pull_i(8'h00),
    .ext_val_i(pb_ext), .ext_en_i(ext_en), .level_o(pb_lvl));
  ebpc_pin_model i_pe (.clk_i(clk), .dev_out_i(pe_o), .dev_oe_i(pe_oe), .pull_i(pull),
    .ext_val_i(pe_ext), .ext_en_i(ext_en), .level_o(pe_lvl));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask

  task automatic do_reset(input logic [2:0] m, input logic e);
    @(posedge clk);
    rst <= 1'b1;
    mode <= m;
    emulate_port_e_flag <= e;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  // request held until ack is sampled high, then released for at least one cycle
  task automatic wb(input logic w, input logic [3:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {2'b00, idx, 2'b00};
    sel <= 4'h1;
    dat <= {24'h000000, wd};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 16);
    rd = dat_o[7:0];
    ext_seen = ext;
    if (n >= 16) begin
      miscompares++;
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic rdchk(input logic [3:0] idx, input logic [7:0] exp, input logic ex);
    wb(1'b0, idx, 8'h00);
    check({8'h00, rd}, {8'h00, exp});
    check({15'h0000, ext_seen}, {15'h0000, ex});
  endtask

  task automatic run_bus(input logic wide, input logic ram, input logic w, input logic [15:0] a,
                         input logic [2:0] ctl, input logic [15:0] papb);
    @(posedge clk);
    cpu_req <= 1'b1;
    cpu_wide <= wide;
    cpu_ram <= ram;
    cpu_we <= w;
    cpu_addr <= a;
    cpu_wdata <= 16'hc35a;
    addr_phase <= 1'b1;
    settle();
    check({13'h0000, pe_o[3], pb_o[0], pe_o[2]}, {13'h0000, ctl});
    check({pa_o, pb_o}, a);
    if (w) begin
      @(posedge clk);
      addr_phase <= 1'b0;
      settle();
      check({pa_oe, pb_oe}, 16'hffff);
      check({pa_o, pb_o}, papb);
    end
    @(posedge clk);
    cpu_req <= 1'b0;
    addr_phase <= 1'b1;
  endtask

  initial begin
    #50000;
    miscompares++;
    give_verdict();
  end

  initial begin
    do_reset(3'h0, 1'b0);
    rdchk(4'ha, 8'h90, 1'b0);
    wb(1'b1, 4'h2, 8'hf0);
    wb(1'b1, 4'h0, 8'ha5);
    wb(1'b1, 4'h3, 8'h0f);
    rdchk(4'h3, 8'h0f, 1'b0);
    rdchk(4'h0, 8'hac, 1'b0);
    rdchk(4'h4, 8'h00, 1'b1);
    check({pa_oe, pa_o & pa_oe}, 16'hf0a0);
    wb(1'b1, 4'h8, 8'h55);
    wb(1'b1, 4'h9, 8'hff);
    rdchk(4'h8, 8'h56, 1'b0);
    settle();
    check({pe_oe, pe_o & pe_oe}, 16'hfc54);
    wb(1'b1, 4'h9, 8'h0c);
    wb(1'b1, 4'he, 8'h01);
    settle();
    check({8'h00, pull}, 16'h0083);
    do_reset(3'h2, 1'b0);
    rdchk(4'ha, 8'h00, 1'b0);
    check({8'h00, pe_oe & 8'hf4}, 16'h0090);
    rdchk(4'h0, 8'h00, 1'b1);
    rdchk(4'h3, 8'h00, 1'b1);
    wb(1'b1, 4'ha, 8'hcc);
    rdchk(4'ha, 8'h8c, 1'b0);
    wb(1'b1, 4'ha, 8'h02);
    rdchk(4'ha, 8'h8e, 1'b0);
    run_bus(1'b0, 1'b0, 1'b1, 16'h1235, 3'b010, 16'h5a35);
    run_bus(1'b1, 1'b0, 1'b1, 16'h5678, 3'b000, 16'hc378);
    do_reset(3'h5, 1'b1);
    rdchk(4'ha, 8'h2c, 1'b0);
    rdchk(4'h8, 8'h00, 1'b1);
    check({pe_oe, pe_o & 8'he0}, 16'hfca0);
    run_bus(1'b0, 1'b0, 1'b0, 16'h1234, 3'b101, 16'h0000);
    run_bus(1'b0, 1'b0, 1'b1, 16'h1235, 3'b010, 16'hc35a);
    run_bus(1'b1, 1'b0, 1'b0, 16'h1234, 3'b001, 16'h0000);
    run_bus(1'b1, 1'b0, 1'b1, 16'h5678, 3'b000, 16'hc35a);
    run_bus(1'b1, 1'b1, 1'b1, 16'h5679, 3'b110, 16'h5ac3);
    wb(1'b1, 4'ha, 8'hc0);
    rdchk(4'ha, 8'h2c, 1'b0);
    wb(1'b1, 4'ha, 8'hc0);
    rdchk(4'ha, 8'hc0, 1'b0);
    check({pe_oe & 8'hc0, pe_o & 8'h40}, 16'h4040);
    rdchk(4'hf, 8'h1d, 1'b0);
    wb(1'b1, 4'ha, 8'he2);
    settle();
    check({pe_oe & 8'hc0, pe_o & 8'hc0}, 16'hc080);
    do_reset(3'h6, 1'b0);
    rdchk(4'ha, 8'h00, 1'b1);
    rdchk(4'h1, 8'h00, 1'b1);
    rdchk(4'h9, 8'h00, 1'b1);
    wb(1'b1, 4'ha, 8'h00);
    settle();
    check({pe_oe & 8'h40, pe_o & 8'h40}, 16'h4040);
    do_reset(3'h1, 1'b0);
    rdchk(4'hf, 8'h01, 1'b0);
    rdchk(4'h0, 8'h3c, 1'b0);
    do_reset(3'h3, 1'b0);
    rdchk(4'ha, 8'h00, 1'b0);
    rdchk(4'h0, 8'h00, 1'b1);
    do_reset(3'h4, 1'b0);
    rdchk(4'ha, 8'h2c, 1'b0);
    rdchk(4'h9, 8'h00, 1'b0);
    give_verdict();
  end
endmodule
`default_nettype wire
